// ===== rgc_pkg.sv
// Notes on behaviour
// - Gain choice 000 lets the automatic loop pick any of six gain steps.
// - Codes 001 to 110 force steps G1 to G6; code 111 is reserved.
// - The same acquisition sequence runs in packet and in continuous mode.
// - After enable, wait until strength exceeds trigger on two consecutive samples.
// - After the double trigger, the most suitable gain step is chosen automatically.
// - The chosen step is held for the packet and shown in the readback field.
// - Packet mode without auto rearm keeps the same step for the next packet.
// - With auto rearm, wait again after buffer drained and the hold-off elapsed.
// - Writing one to the rearm request bit restarts acquisition in any mode while the receiver is enabled.
// - Automatic start-up correction uses the correction filter width during the first acquisition after enable.
// - The impedance select bit picks the 50 ohm or the 200 ohm input.
// - A strength sample takes two bit periods, which spaces the trigger samples.
// - The strength readback is valid only while it exceeds the trigger level.
package rgc_pkg;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] TRIG_OFS = 8'h04;
    localparam logic [7:0] THLO_OFS = 8'h08;
    localparam logic [7:0] THHI_OFS = 8'h0C;
    localparam logic [7:0] TIME_OFS = 8'h10;
    localparam logic [7:0] FILT_OFS = 8'h14;
    localparam logic [7:0] STAT_OFS = 8'h18;

    localparam int CTRL_RX_EN_BIT = 0;
    localparam int CTRL_PKT_BIT = 1;
    localparam int CTRL_AUTO_BIT = 2;
    localparam int CTRL_FC_BIT = 3;
    localparam int CTRL_ZIN_BIT = 4;
    localparam int CTRL_CHOICE_LSB = 5;
    localparam int CTRL_REARM_BIT = 8;
    localparam int TIME_HOLD_LSB = 16;
    localparam int FILT_FC_LSB = 8;
    localparam int STAT_WAIT_BIT = 3;
    localparam int STAT_LOCK_BIT = 4;
    localparam int STAT_VALID_BIT = 5;
    localparam int STAT_CORR_BIT = 6;
    localparam int STAT_LEVEL_LSB = 8;

    localparam logic [7:0] TRIG_RST = 8'h80;
    localparam logic [4:0][7:0] TH_RST = {8'hC0, 8'hA0, 8'h80, 8'h60, 8'h40};
    localparam logic [15:0] BIT_PERIOD_RST = 16'h0014;
    localparam logic [15:0] HOLDOFF_RST = 16'h0000;
    localparam logic [4:0] CHAN_BW_RST = 5'h00;
    localparam logic [4:0] FC_BW_RST = 5'h00;

    localparam logic [2:0] GAIN_AUTO = 3'h0;
    localparam logic [2:0] GAIN_G1 = 3'h1;
    localparam logic [2:0] GAIN_G6 = 3'h6;
    localparam logic [2:0] GAIN_RSVD = 3'h7;

    // Samples are spaced by the strength acquisition time, in bit periods.
    localparam int SAMPLE_BITS = 2;

    typedef enum logic [1:0] {st_idle, st_wait, st_hold, st_holdoff} rgc_fsm_t;

    typedef struct packed {
        logic rx_en;
        logic pkt_mode;
        logic auto_rearm;
        logic fc_auto;
        logic zin_sel;
        logic [2:0] choice;
        logic [7:0] trig;
        logic [4:0][7:0] th;
        logic [15:0] bit_period;
        logic [15:0] holdoff;
        logic [4:0] chan_bw;
        logic [4:0] fc_bw;
    } rgc_cfg_t;

    typedef struct packed {
        rgc_cfg_t cfg;
        rgc_fsm_t fsm;
        logic hit;
        logic startup;
        logic pend;
        logic [15:0] bit_cnt;
        logic phase;
        logic tick;
        logic [15:0] hold_cnt;
        logic [7:0] level;
        logic [2:0] gain;
        logic [4:0] filt;
        logic waiting;
        logic locked;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } rgc_state_t;

    // Step is G1 plus one plus the index of the highest threshold the level is above.
    function automatic logic [2:0] auto_gain(input logic [7:0] level,
                                             input logic [4:0][7:0] th);
        logic [2:0] g;
        g = GAIN_G1;
        for (int i = 0; i < 5; i++) begin
            if (level > th[i]) begin
                g = GAIN_G1 + 3'(i + 1);
            end
        end
        return g;
    endfunction : auto_gain

endpackage : rgc_pkg

// ===== rgc_sync.sv
`timescale 1ns/1ps
module rgc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule : rgc_sync

// ===== rgc_gain_ctrl.sv
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module rgc_gain_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] strength_level,
    input wire logic packet_done,
    input wire logic fifo_empty_in,
    output logic [2:0] lna_gain_step,
    output logic input_impedance_select,
    output logic [4:0] filter_width_sel,
    output logic rx_waiting,
    output logic gain_locked
);
    rgc_pkg::rgc_state_t s_r;
    rgc_pkg::rgc_state_t s_nxt;
    logic fifo_empty_s;
    logic access;
    logic done;
    logic rearm_wr;
    logic bit_tick;
    logic manual;
    logic level_valid;
    logic corr_active;

    // The buffer-empty level comes from another clock domain.
    rgc_sync #(.WIDTH(1)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(fifo_empty_in),
        .sync_out(fifo_empty_s)
    );

    assign access = psel && penable;
    assign done = access && s_r.pready;
    assign rearm_wr = done && pwrite && (paddr == rgc_pkg::CTRL_OFS)
        && pwdata[rgc_pkg::CTRL_REARM_BIT];
    assign manual = (s_r.cfg.choice != rgc_pkg::GAIN_AUTO)
        && (s_r.cfg.choice != rgc_pkg::GAIN_RSVD);
    assign level_valid = s_r.level > s_r.cfg.trig;
    assign corr_active = s_r.cfg.fc_auto && s_r.startup && (s_r.fsm == rgc_pkg::st_wait);
    assign bit_tick = (s_r.fsm != rgc_pkg::st_idle)
        && (s_r.bit_cnt >= s_r.cfg.bit_period - 16'h0001);

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        s_nxt.pready = access && !s_r.pready;

        // Bit-period timebase; a strength sample is taken every second bit.
        if (s_r.fsm == rgc_pkg::st_idle) begin
            s_nxt.bit_cnt = 16'h0000;
            s_nxt.phase = 1'b0;
        end else if (bit_tick) begin
            s_nxt.bit_cnt = 16'h0000;
            s_nxt.phase = !s_r.phase;
            if (s_r.phase) begin
                s_nxt.tick = 1'b1;
                s_nxt.level = strength_level;
            end
        end else begin
            s_nxt.bit_cnt = s_r.bit_cnt + 16'h0001;
        end

        // Read data and errors are prepared in the first access cycle.
        if (access && !s_r.pready) begin
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata = 32'h0000_0000;
            if (paddr == rgc_pkg::CTRL_OFS) begin
                s_nxt.prdata[rgc_pkg::CTRL_RX_EN_BIT] = s_r.cfg.rx_en;
                s_nxt.prdata[rgc_pkg::CTRL_PKT_BIT] = s_r.cfg.pkt_mode;
                s_nxt.prdata[rgc_pkg::CTRL_AUTO_BIT] = s_r.cfg.auto_rearm;
                s_nxt.prdata[rgc_pkg::CTRL_FC_BIT] = s_r.cfg.fc_auto;
                s_nxt.prdata[rgc_pkg::CTRL_ZIN_BIT] = s_r.cfg.zin_sel;
                s_nxt.prdata[rgc_pkg::CTRL_CHOICE_LSB +: 3] = s_r.cfg.choice;
            end else if (paddr == rgc_pkg::TRIG_OFS) begin
                s_nxt.prdata[7:0] = s_r.cfg.trig;
            end else if (paddr == rgc_pkg::THLO_OFS) begin
                s_nxt.prdata = s_r.cfg.th[3:0];
            end else if (paddr == rgc_pkg::THHI_OFS) begin
                s_nxt.prdata[7:0] = s_r.cfg.th[4];
            end else if (paddr == rgc_pkg::TIME_OFS) begin
                s_nxt.prdata = {s_r.cfg.holdoff, s_r.cfg.bit_period};
            end else if (paddr == rgc_pkg::FILT_OFS) begin
                s_nxt.prdata[4:0] = s_r.cfg.chan_bw;
                s_nxt.prdata[rgc_pkg::FILT_FC_LSB +: 5] = s_r.cfg.fc_bw;
            end else if (paddr == rgc_pkg::STAT_OFS) begin
                s_nxt.prdata[2:0] = s_r.gain;
                s_nxt.prdata[rgc_pkg::STAT_WAIT_BIT] = s_r.waiting;
                s_nxt.prdata[rgc_pkg::STAT_LOCK_BIT] = s_r.locked;
                s_nxt.prdata[rgc_pkg::STAT_VALID_BIT] = level_valid;
                s_nxt.prdata[rgc_pkg::STAT_CORR_BIT] = corr_active;
                // A level at or below the trigger is not a usable reading.
                s_nxt.prdata[rgc_pkg::STAT_LEVEL_LSB +: 8] = level_valid ? s_r.level : 8'h00;
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end else if (!access) begin
            s_nxt.pslverr = 1'b0;
        end

        if (done && pwrite) begin
            if (paddr == rgc_pkg::CTRL_OFS) begin
                s_nxt.cfg.rx_en = pwdata[rgc_pkg::CTRL_RX_EN_BIT];
                s_nxt.cfg.pkt_mode = pwdata[rgc_pkg::CTRL_PKT_BIT];
                s_nxt.cfg.auto_rearm = pwdata[rgc_pkg::CTRL_AUTO_BIT];
                s_nxt.cfg.fc_auto = pwdata[rgc_pkg::CTRL_FC_BIT];
                s_nxt.cfg.zin_sel = pwdata[rgc_pkg::CTRL_ZIN_BIT];
                s_nxt.cfg.choice = pwdata[rgc_pkg::CTRL_CHOICE_LSB +: 3];
            end else if (paddr == rgc_pkg::TRIG_OFS) begin
                s_nxt.cfg.trig = pwdata[7:0];
            end else if (paddr == rgc_pkg::THLO_OFS) begin
                s_nxt.cfg.th[3:0] = pwdata;
            end else if (paddr == rgc_pkg::THHI_OFS) begin
                s_nxt.cfg.th[4] = pwdata[7:0];
            end else if (paddr == rgc_pkg::TIME_OFS) begin
                s_nxt.cfg.bit_period = pwdata[15:0];
                s_nxt.cfg.holdoff = pwdata[rgc_pkg::TIME_HOLD_LSB +: 16];
            end else if (paddr == rgc_pkg::FILT_OFS) begin
                s_nxt.cfg.chan_bw = pwdata[4:0];
                s_nxt.cfg.fc_bw = pwdata[rgc_pkg::FILT_FC_LSB +: 5];
            end
        end

        // The sequence ignores packet or continuous mode except for auto rearm.
        case (s_r.fsm)
            rgc_pkg::st_idle: begin
                if (s_r.cfg.rx_en) begin
                    s_nxt.fsm = rgc_pkg::st_wait;
                    s_nxt.startup = 1'b1;
                    s_nxt.hit = 1'b0;
                end
            end
            rgc_pkg::st_wait: begin
                // While waiting in automatic mode the front end sits at full gain.
                s_nxt.gain = manual ? s_r.cfg.choice : rgc_pkg::GAIN_G1;
                if (s_r.tick) begin
                    if (level_valid) begin
                        s_nxt.hit = 1'b1;
                        if (s_r.hit) begin
                            s_nxt.fsm = rgc_pkg::st_hold;
                            s_nxt.hit = 1'b0;
                            s_nxt.startup = 1'b0;
                            s_nxt.gain = manual ? s_r.cfg.choice
                                : rgc_pkg::auto_gain(s_r.level, s_r.cfg.th);
                        end
                    end else begin
                        s_nxt.hit = 1'b0;
                    end
                end
            end
            rgc_pkg::st_hold: begin
                // Without auto rearm the held step carries over to the next packet.
                if (s_r.cfg.pkt_mode && s_r.cfg.auto_rearm && packet_done) begin
                    s_nxt.pend = 1'b1;
                end
                if (s_r.pend && fifo_empty_s) begin
                    s_nxt.fsm = rgc_pkg::st_holdoff;
                    s_nxt.pend = 1'b0;
                    s_nxt.hold_cnt = 16'h0000;
                end
            end
            rgc_pkg::st_holdoff: begin
                // The hold-off lets the far transmitter ramp down before re-arming.
                if (s_r.hold_cnt >= s_r.cfg.holdoff) begin
                    s_nxt.fsm = rgc_pkg::st_wait;
                    s_nxt.hit = 1'b0;
                end else if (bit_tick) begin
                    s_nxt.hold_cnt = s_r.hold_cnt + 16'h0001;
                end
            end
            default: begin
                s_nxt.fsm = rgc_pkg::st_idle;
            end
        endcase

        if (!s_r.cfg.rx_en) begin
            s_nxt.fsm = rgc_pkg::st_idle;
            s_nxt.hit = 1'b0;
            s_nxt.pend = 1'b0;
        end else if (rearm_wr && s_r.fsm != rgc_pkg::st_idle) begin
            s_nxt.fsm = rgc_pkg::st_wait;
            s_nxt.hit = 1'b0;
            s_nxt.pend = 1'b0;
        end

        s_nxt.filt = corr_active ? s_r.cfg.fc_bw : s_r.cfg.chan_bw;
        s_nxt.waiting = s_nxt.fsm == rgc_pkg::st_wait;
        s_nxt.locked = (s_nxt.fsm == rgc_pkg::st_hold) || (s_nxt.fsm == rgc_pkg::st_holdoff);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{cfg: '{trig: rgc_pkg::TRIG_RST, th: rgc_pkg::TH_RST,
                            bit_period: rgc_pkg::BIT_PERIOD_RST,
                            holdoff: rgc_pkg::HOLDOFF_RST,
                            chan_bw: rgc_pkg::CHAN_BW_RST, fc_bw: rgc_pkg::FC_BW_RST,
                            default: '0},
                     fsm: rgc_pkg::st_idle, gain: rgc_pkg::GAIN_G1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign lna_gain_step = s_r.gain;
    assign input_impedance_select = s_r.cfg.zin_sel;
    assign filter_width_sel = s_r.filt;
    assign rx_waiting = s_r.waiting;
    assign gain_locked = s_r.locked;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence second_hit_s;
        s_r.fsm == rgc_pkg::st_wait && s_r.tick && level_valid && s_r.hit;
    endsequence
    sequence no_override_s;
        s_r.cfg.rx_en && !rearm_wr;
    endsequence

    lock_on_two_a: assert property (second_hit_s and no_override_s |=> gain_locked)
        else $error("Second consecutive hit did not lock gain");
    no_single_lock_a: assert property ($rose(gain_locked) |-> $past(s_r.hit) && $past(s_r.tick))
        else $error("Gain locked without two consecutive hits");
    manual_step_a: assert property (second_hit_s and no_override_s and manual
        |=> lna_gain_step == $past(s_r.cfg.choice))
        else $error("Manual gain step not applied");
    auto_step_a: assert property (second_hit_s and no_override_s and !manual
        |=> lna_gain_step == rgc_pkg::auto_gain($past(s_r.level), $past(s_r.cfg.th)))
        else $error("Automatic gain step mismatch");
    hold_stable_a: assert property (gain_locked && $past(gain_locked) |-> $stable(lna_gain_step))
        else $error("Gain step changed while held");
    no_rearm_keep_a: assert property (s_r.fsm == rgc_pkg::st_hold && !s_r.cfg.auto_rearm
        && !s_r.pend and no_override_s |=> s_r.fsm == rgc_pkg::st_hold)
        else $error("Held step left without auto rearm");
    holdoff_wait_a: assert property (s_r.fsm == rgc_pkg::st_holdoff
        && s_r.hold_cnt < s_r.cfg.holdoff |=> s_r.fsm != rgc_pkg::st_wait || $past(rearm_wr))
        else $error("Rearm before hold-off elapsed");
    rearm_req_a: assert property (rearm_wr && s_r.cfg.rx_en && s_r.fsm != rgc_pkg::st_idle
        |=> rx_waiting ##0 !gain_locked)
        else $error("Rearm request did not restart acquisition");
    corr_filter_a: assert property (corr_active
        |=> filter_width_sel == $past(s_r.cfg.fc_bw))
        else $error("Correction filter width not used");
    sample_space_a: assert property (s_r.tick |-> $past(s_r.phase) && !s_r.phase)
        else $error("Strength sample spacing wrong");
    level_read_a: assert property (done && !pwrite && paddr == rgc_pkg::STAT_OFS
        && prdata[rgc_pkg::STAT_LEVEL_LSB +: 8] != 8'h00 |-> prdata[rgc_pkg::STAT_VALID_BIT])
        else $error("Strength reading shown below trigger");
endmodule : rgc_gain_ctrl

// ===== rgc_radio_model.sv
`timescale 1ns/1ps
module rgc_radio_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] sig_level,
    input wire logic pkt_req,
    input wire logic [7:0] fifo_words,
    output logic [7:0] strength_level,
    output logic packet_done,
    output logic fifo_empty_in
);
    logic req_r;

    // The level only moves when the bench says so, so acquisition sees a steady preamble.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strength_level <= 8'h00;
            packet_done <= 1'h0;
            fifo_empty_in <= 1'h1;
            req_r <= 1'h0;
        end else begin
            strength_level <= sig_level;
            req_r <= pkt_req;
            packet_done <= pkt_req & ~req_r;
            fifo_empty_in <= (fifo_words == 8'h00);
        end
    end
endmodule : rgc_radio_model

// ===== rgc_gain_ctrl_bench.sv
`timescale 1ns/1ps
module rgc_gain_ctrl_bench;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] sig_level = 8'h00;
    logic pkt_req = 1'h0;
    logic [7:0] fifo_words = 8'h00;
    logic [7:0] strength_level;
    logic packet_done;
    logic fifo_empty_in;
    logic [2:0] lna_gain_step;
    logic input_impedance_select;
    logic [4:0] filter_width_sel;
    logic rx_waiting;
    logic gain_locked;
    int num_errors = 0;
    int total_checks = 0;
    logic [31:0] rd_val;
    logic rd_err;

    always #25 pclk = ~pclk;

    rgc_gain_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strength_level(strength_level), .packet_done(packet_done),
        .fifo_empty_in(fifo_empty_in), .lna_gain_step(lna_gain_step),
        .input_impedance_select(input_impedance_select), .filter_width_sel(filter_width_sel),
        .rx_waiting(rx_waiting), .gain_locked(gain_locked));

    rgc_radio_model radio_u (.pclk(pclk), .presetn(presetn), .sig_level(sig_level),
        .pkt_req(pkt_req), .fifo_words(fifo_words), .strength_level(strength_level),
        .packet_done(packet_done), .fifo_empty_in(fifo_empty_in));

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // The request is held until the edge at which pready is seen high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd_val = prdata;
        rd_err = pslverr;
        chk("pready", 32'h1, 32'(pready));
        @(posedge pclk);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'h0, a, 32'h0);
        chk(name, exp, rd_val);
        chk("pslverr", 32'(e), 32'(rd_err));
    endtask : rd_chk

    task cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc

    // Bounded wait on the waiting flag (sel 0) or the lock flag (sel 1).
    task wait_for(input logic sel, input logic want);
        int n;
        n = 0;
        #1;
        while ((sel ? gain_locked : rx_waiting) !== want && n < 60) begin
            cyc(1);
            n++;
        end
        chk(sel ? "gain_locked" : "rx_waiting", 32'(want), 32'(sel ? gain_locked : rx_waiting));
    endtask : wait_for

    function automatic logic [31:0] ctrl(input logic en, input logic pkt, input logic au,
                                         input logic fc, input logic zin, input logic [2:0] ch,
                                         input logic rr);
        return {23'h0, rr, ch, zin, fc, au, pkt, en};
    endfunction : ctrl

    task lvl(input logic [7:0] v);
        @(posedge pclk);
        sig_level <= v;
    endtask : lvl

    task t_reset;
        #1;
        chk("gain out", 32'h1, 32'(lna_gain_step));
        rd_chk("ctrl", rgc_pkg::CTRL_OFS, 32'h0, 1'h0);
        rd_chk("trig", rgc_pkg::TRIG_OFS, 32'h80, 1'h0);
        rd_chk("thlo", rgc_pkg::THLO_OFS, 32'hA0806040, 1'h0);
        rd_chk("thhi", rgc_pkg::THHI_OFS, 32'hC0, 1'h0);
        rd_chk("time", rgc_pkg::TIME_OFS, 32'h14, 1'h0);
        rd_chk("filt", rgc_pkg::FILT_OFS, 32'h0, 1'h0);
        apb(1'h1, rgc_pkg::STAT_OFS, 32'hFFFFFFFF);
        rd_chk("stat", rgc_pkg::STAT_OFS, 32'h1, 1'h0);
        rd_chk("unmapped", 8'h1C, 32'h0, 1'h1);
        $display("test reset done");
    endtask : t_reset

    task t_wait;
        apb(1'h1, rgc_pkg::TRIG_OFS, 32'h20);
        apb(1'h1, rgc_pkg::TIME_OFS, 32'h2);
        lvl(8'h10);
        apb(1'h1, rgc_pkg::CTRL_OFS, ctrl(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0));
        cyc(12);
        chk("waiting", 32'h1, 32'(rx_waiting));
        chk("locked", 32'h0, 32'(gain_locked));
        rd_chk("stat low", rgc_pkg::STAT_OFS, 32'h9, 1'h0);
        lvl(8'h90);
        cyc(4);
        chk("early lock", 32'h0, 32'(gain_locked));
        wait_for(1'h1, 1'h1);
        chk("gain", 32'h4, 32'(lna_gain_step));
        rd_chk("stat lock", rgc_pkg::STAT_OFS, 32'h9034, 1'h0);
        $display("test wait done");
    endtask : t_wait

    task t_steps;
        logic [7:0] lv [7];
        logic [2:0] ex [7];
        lv = '{8'h30, 8'h41, 8'h61, 8'h80, 8'h81, 8'hA1, 8'hFF};
        ex = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h6};
        for (int i = 0; i < 7; i++) begin
            lvl(lv[i]);
            apb(1'h1, rgc_pkg::CTRL_OFS, ctrl(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h0, 1'h1));
            wait_for(1'h0, 1'h1);
            wait_for(1'h1, 1'h1);
            chk("auto gain", 32'(ex[i]), 32'(lna_gain_step));
        end
        lvl(8'h81);
        for (int c = 1; c < 8; c++) begin
            apb(1'h1, rgc_pkg::CTRL_OFS, ctrl(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'(c), 1'h1));
            wait_for(1'h0, 1'h1);
            wait_for(1'h1, 1'h1);
            apb(1'h0, rgc_pkg::STAT_OFS, 32'h0);
            chk("manual gain", (c == 7) ? 32'h4 : 32'(c), 32'(rd_val[2:0]));
        end
        lvl(8'hA1);
        apb(1'h1, rgc_pkg::CTRL_OFS, ctrl(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 3'h0, 1'h1));
        wait_for(1'h0, 1'h1);
        wait_for(1'h1, 1'h1);
        chk("cont gain", 32'h5, 32'(lna_gain_step));
        $display("test steps done");
    endtask : t_steps

    task pulse_pkt;
        @(posedge pclk);
        pkt_req <= 1'h1;
        @(posedge pclk);
        pkt_req <= 1'h0;
    endtask : pulse_pkt

    task t_rearm;
        lvl(8'h81);
        apb(1'h1, rgc_pkg::CTRL_OFS, ctrl(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h0, 1'h1));
        wait_for(1'h0, 1'h1);
        wait_for(1'h1, 1'h1);
        lvl(8'hFF);
        pulse_pkt();
        cyc(20);
        chk("kept lock", 32'h1, 32'(gain_locked));
        chk("kept gain", 32'h4, 32'(lna_gain_step));
        @(posedge pclk);
        fifo_words <= 8'h01;
        apb(1'h1, rgc_pkg::TIME_OFS, 32'h00030002);
        apb(1'h1, rgc_pkg::CTRL_OFS, ctrl(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 3'h0, 1'h0));
        pulse_pkt();
        cyc(20);
        chk("full fifo", 32'h1, 32'(gain_locked));
        @(posedge pclk);
        fifo_words <= 8'h00;
        cyc(4);
        chk("holdoff", 32'h1, 32'(gain_locked));
        wait_for(1'h0, 1'h1);
        wait_for(1'h1, 1'h1);
        chk("new gain", 32'h6, 32'(lna_gain_step));
        $display("test rearm done");
    endtask : t_rearm

    task t_filt;
        apb(1'h1, rgc_pkg::FILT_OFS, 32'h00000A05);
        apb(1'h1, rgc_pkg::CTRL_OFS, 32'h0);
        lvl(8'h10);
        apb(1'h1, rgc_pkg::CTRL_OFS, ctrl(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 3'h0, 1'h0));
        cyc(3);
        chk("fc width", 32'h0A, 32'(filter_width_sel));
        chk("zin", 32'h1, 32'(input_impedance_select));
        lvl(8'h90);
        wait_for(1'h1, 1'h1);
        cyc(2);
        chk("chan width", 32'h05, 32'(filter_width_sel));
        apb(1'h1, rgc_pkg::CTRL_OFS, 32'h0);
        cyc(2);
        chk("zin off", 32'h0, 32'(input_impedance_select));
        chk("idle", 32'h0, 32'({rx_waiting, gain_locked}));
        $display("test filter done");
    endtask : t_filt

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_wait();
        t_steps();
        t_rearm();
        t_filt();
        give_verdict();
    end

    // The tests need several hundred cycles; this span leaves a wide margin.
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        $display("FAIL watchdog expected finish seen hang");
        give_verdict();
    end
endmodule : rgc_gain_ctrl_bench
